// [rtl/padc_pkg.sv]
// Behaviour
// RULE_01 - Format pin low inverts the top bit; high leaves it, offset binary.
// RULE_02 - Input is held at the encode low-to-high edge; samples start there.
// RULE_03 - Complement encode is the inverse phase; its fall equals true rise.
// RULE_04 - Encode counts as high whenever true input exceeds complement input.
// RULE_05 - Track input while encode low; hold and pass on while encode high.
// RULE_06 - Four pipelined stages on alternate phases, results delayed and merged; here all four shift whole words on each encode rise.
// RULE_07 - Word appears five encode cycles after sampling, one word per cycle.
// RULE_08 - Active-low drive enable low drives outputs; high floats them.
// RULE_09 - Capturing logic registers the word on the strobe's rising edge.
// RULE_10 - Fourteen-bit word, bit zero least significant, bit thirteen most.
// RULE_11 - Overflow flag high when input passed either full-scale limit.
// RULE_12 - Overflow flag travels with its own word under the same strobe.
package padc_pkg;

  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int SAMPLE_WIDTH = 14;
  localparam int STAGE_COUNT = 4;
  localparam int LATENCY_CYCLES = 5;
  localparam int MSB_POS = 13;
  localparam logic [13:0] WORD_RESET = 14'h0000;

  typedef struct packed {
    logic overflow;
    logic [13:0] word;
  } padc_result_s;

endpackage

// [rtl/padc_skid.sv]
`timescale 1ns/10ps
`default_nettype none
module padc_skid #(
  parameter int WIDTH = 15
) (
  input wire logic ref_clk_in, // Clock
  input wire logic rst_n_in, // Sync reset, active low
  input wire logic in_valid_in, // Upstream valid
  output logic in_ready_out, // Upstream ready
  input wire logic [WIDTH-1:0] in_data_in, // Upstream data
  output logic out_valid_out, // Downstream valid
  input wire logic out_ready_in, // Downstream ready
  output logic [WIDTH-1:0] out_data_out // Downstream data
);
  logic [WIDTH-1:0] mem [0:1];
  logic [WIDTH-1:0] next_mem [0:1];
  logic [1:0] count;
  logic [1:0] next_count;
  logic rd_ptr;
  logic next_rd_ptr;
  logic wr_ptr;
  logic next_wr_ptr;
  logic push;
  logic pop;

  assign in_ready_out = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    next_mem[0] = mem[0];
    next_mem[1] = mem[1];
    next_count = count;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    if (push) begin
      next_mem[wr_ptr] = in_data_in;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      mem[0] <= '0;
      mem[1] <= '0;
      count <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else begin
      mem[0] <= next_mem[0];
      mem[1] <= next_mem[1];
      count <= next_count;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
    end
  end
endmodule
`default_nettype wire

// [rtl/padc_port.sv]
`timescale 1ns/10ps
`default_nettype none
module padc_port #(
  parameter int WIDTH = padc_pkg::SAMPLE_WIDTH,
  parameter int STAGES = padc_pkg::STAGE_COUNT,
  parameter int LATENCY = padc_pkg::LATENCY_CYCLES
) (
  input wire logic ref_clk_in, // System clock, 125 MHz
  input wire logic rst_n_in, // Sync reset, active low
  input wire logic encode_clock_pair_p_in, // True encode, sampled level
  input wire logic encode_clock_pair_n_in, // Complement encode, sampled level
  input wire logic [13:0] raw_sample_in, // Quantised analog input
  input wire logic over_range_in, // Input past positive full scale
  input wire logic under_range_in, // Input past negative full scale
  input wire logic format_select_n_in, // Low gives two's complement
  input wire logic drive_enable_n_in, // Low drives outputs
  input wire logic sink_ready_in, // Capture side can accept
  output logic [13:0] sample_word_out, // Output word
  output logic [13:0] sample_word_oe_n_out, // Low while driven
  output logic range_overflow_flag_out, // Overflow of this word
  output logic range_overflow_flag_oe_n_out, // Low while driven
  output logic data_valid_strobe_out // Rises when word valid
);
  // ****************************************
  // Encode phase detection
  // ****************************************
  logic enc_high;
  logic enc_prev;
  logic next_enc_prev;
  logic enc_rise;

  assign enc_high = encode_clock_pair_p_in && !encode_clock_pair_n_in; // RULE_04 RULE_03
  assign enc_rise = enc_high && !enc_prev; // RULE_02

  // ****************************************
  // Track and hold
  // ****************************************
  logic [14:0] track;
  logic [14:0] next_track;
  logic [14:0] held;
  logic [14:0] next_held;

  always_comb begin
    next_enc_prev = enc_high;
    next_track = track;
    next_held = held;
    if (!enc_high) begin
      next_track = {over_range_in || under_range_in, raw_sample_in}; // RULE_05 RULE_11
    end
    if (enc_rise) begin
      next_held = track; // RULE_02 RULE_05
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      enc_prev <= 1'b0;
      track <= 15'h0000;
      held <= 15'h0000;
    end else begin
      enc_prev <= next_enc_prev;
      track <= next_track;
      held <= next_held;
    end
  end

  // ****************************************
  // Stage pipeline, one step per encode cycle
  // ****************************************
  // Stage timing abstracted to whole encode cycles; alignment delay folded in
  // Held word plus one entry per stage gives the full latency at the next rise
  logic [14:0] pipe [0:STAGES-1];
  logic [14:0] next_pipe [0:STAGES-1];

  always_comb begin
    for (int i = 0; i < STAGES; i++) begin
      next_pipe[i] = pipe[i];
    end
    if (enc_rise) begin
      next_pipe[0] = held; // RULE_06
      for (int i = 1; i < STAGES; i++) begin
        next_pipe[i] = pipe[i-1]; // RULE_06 RULE_07
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_pipe
      always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
          pipe[g] <= 15'h0000;
        end else begin
          pipe[g] <= next_pipe[g];
        end
      end
    end
  endgenerate

  // Word leaving the pipe; the held word itself is one cycle old already
  logic [14:0] result;
  logic [LATENCY-1:0] fill;
  logic [LATENCY-1:0] next_fill;
  padc_pkg::padc_result_s fmt;

  always_comb begin
    next_fill = fill;
    if (enc_rise) begin
      next_fill = {fill[LATENCY-2:0], 1'b1};
    end
    result = pipe[STAGES-1];
    fmt.overflow = result[14]; // RULE_12
    fmt.word = result[13:0]; // RULE_10
    fmt.word[padc_pkg::MSB_POS] = result[13] ^ ~format_select_n_in; // RULE_01
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      fill <= '0;
    end else begin
      fill <= next_fill;
    end
  end

  // ****************************************
  // Two-entry buffer; while the sink stalls, words arriving after the first two are dropped
  // ****************************************
  logic buf_valid;
  logic buf_ready;
  logic [14:0] buf_data;

  padc_skid #(
    .WIDTH(15)
  ) u_skid (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(enc_rise && fill[LATENCY-1]), // RULE_07
    .in_ready_out(),
    .in_data_in(fmt),
    .out_valid_out(buf_valid),
    .out_ready_in(buf_ready),
    .out_data_out(buf_data)
  );

  // ****************************************
  // Output register and strobe
  // ****************************************
  padc_pkg::padc_result_s out_q;
  padc_pkg::padc_result_s next_out_q;
  logic strobe;
  logic next_strobe;

  // Strobe low one cycle before each new word so it always shows a rising edge
  assign buf_ready = sink_ready_in && !strobe;

  always_comb begin
    next_out_q = out_q;
    next_strobe = 1'b0;
    if (buf_valid && buf_ready) begin
      next_out_q = buf_data; // RULE_12
      next_strobe = 1'b1; // RULE_09
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      out_q <= {1'b0, padc_pkg::WORD_RESET};
      strobe <= 1'b0;
    end else begin
      out_q <= next_out_q;
      strobe <= next_strobe;
    end
  end

  assign sample_word_out = out_q.word; // RULE_10
  assign range_overflow_flag_out = out_q.overflow; // RULE_11
  assign sample_word_oe_n_out = {WIDTH{drive_enable_n_in}}; // RULE_08
  assign range_overflow_flag_oe_n_out = drive_enable_n_in; // RULE_08
  assign data_valid_strobe_out = strobe;
endmodule
`default_nettype wire

// [test/padc_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module padc_asserts (
  input wire logic ref_clk_in, // Clock
  input wire logic rst_n_in, // Reset
  input wire logic encode_clock_pair_p_in, // Encode
  input wire logic encode_clock_pair_n_in, // Encode bar
  input wire logic drive_enable_n_in, // Drive
  input wire logic sink_ready_in, // Ready
  input wire logic [13:0] sample_word_out, // Word
  input wire logic [13:0] sample_word_oe_n_out, // Word oe
  input wire logic range_overflow_flag_out, // Flag
  input wire logic range_overflow_flag_oe_n_out, // Flag oe
  input wire logic data_valid_strobe_out // Strobe
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic encode_clock_pair;
  logic enc_q;
  logic [2:0] rises;
  assign encode_clock_pair = encode_clock_pair_p_in & ~encode_clock_pair_n_in;
  // Saturates, only a lower bound is needed
  always_ff @(posedge ref_clk_in) begin
    enc_q <= encode_clock_pair;
    if (!rst_n_in)
      rises <= 3'h0;
    else if (encode_clock_pair && !enc_q && rises != 3'h7)
      rises <= rises + 3'h1;
  end
  a_oe_word: assert property (
    sample_word_oe_n_out == {14{drive_enable_n_in}}) else $error("word enable wrong");
  a_oe_flag: assert property (
    range_overflow_flag_oe_n_out == drive_enable_n_in) else $error("flag enable wrong");
  a_strobe_gap: assert property (
    data_valid_strobe_out |=> !data_valid_strobe_out) else $error("strobe too long");
  a_word_hold: assert property (
    !data_valid_strobe_out |-> $stable(sample_word_out)) else $error("word moved");
  a_flag_hold: assert property (
    !data_valid_strobe_out |-> $stable(range_overflow_flag_out)) else $error("flag moved");
  a_strobe_ready: assert property (
    $rose(data_valid_strobe_out) |-> $past(sink_ready_in)) else $error("strobe unready");
  a_latency_min: assert property (
    data_valid_strobe_out |-> rises >= 3'h6) else $error("word too early");
  a_start_quiet: assert property (
    $rose(rst_n_in) |-> !data_valid_strobe_out && sample_word_out == 14'h0) else $error("reset");
  cover property (data_valid_strobe_out);
  cover property (data_valid_strobe_out && range_overflow_flag_out);
  cover property (!sink_ready_in && rises == 3'h7);
endmodule
`default_nettype wire

// [test/padc_sink.sv]
`timescale 1ns/10ps
`default_nettype none
module padc_sink (
  input wire logic ref_clk_in, // Clock
  input wire logic stall_in, // Hold off
  input wire logic [13:0] word_in, // Word
  input wire logic [13:0] oe_n_in, // Word enables
  input wire logic flag_in, // Flag
  input wire logic flag_oe_n_in, // Flag enable
  input wire logic strobe_in, // Strobe
  output logic ready_out // Can accept
);
  padc_pkg::padc_result_s got[$];
  logic [13:0] bus;
  logic [13:0] last = 14'h0;
  logic flag_bus;
  logic last_flag = 1'b0;
  assign ready_out = !stall_in;
  // Floating bits show the inverse of the last level
  assign bus = (word_in & ~oe_n_in) | (~last & oe_n_in);
  assign flag_bus = flag_oe_n_in ? ~last_flag : flag_in;
  always @(posedge ref_clk_in) begin
    last <= bus;
    last_flag <= flag_bus;
    if (strobe_in)
      got.push_back({flag_bus, bus});
  end
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, p = 1'b0, n = 1'b1, ovr = 1'b0, und = 1'b0;
  logic fmt_n = 1'b0, den_n = 1'b0, stall = 1'b0, rdy, stb, flag, foe;
  logic [13:0] raw = 14'h0, word, woe;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  padc_port DUT (.ref_clk_in(clk), .rst_n_in(rst_n), .encode_clock_pair_p_in(p),
    .encode_clock_pair_n_in(n), .raw_sample_in(raw), .over_range_in(ovr),
    .under_range_in(und), .format_select_n_in(fmt_n), .drive_enable_n_in(den_n),
    .sink_ready_in(rdy), .sample_word_out(word), .sample_word_oe_n_out(woe),
    .range_overflow_flag_out(flag), .range_overflow_flag_oe_n_out(foe),
    .data_valid_strobe_out(stb));
  padc_sink model (.ref_clk_in(clk), .stall_in(stall), .word_in(word), .oe_n_in(woe),
    .flag_in(flag), .flag_oe_n_in(foe), .strobe_in(stb), .ready_out(rdy));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    tick(8);
    rst_n = 1'b1;
    model.got.delete();
  endtask
  function automatic logic [13:0] val(input int i);
    return 14'h1a5c ^ {i[1:0], 8'h0, i[3:0]};
  endfunction
  // Input and flags change in the high phase to prove the hold
  task automatic period(input logic [13:0] v, input logic o, input logic u, input logic bad);
    p = 1'b0; n = 1'b1; raw = v; ovr = o; und = u;
    tick(2);
    p = 1'b1; n = bad; raw = ~v; ovr = ~o; und = 1'b0;
    tick(2);
  endtask
  task automatic t_stream(input logic f);
    fmt_n = f;
    do_reset();
    period(14'h3fff, 1'b1, 1'b0, 1'b1);
    // Nine samples at a latency of five let exactly four words out
    for (int i = 1; i <= 9; i++)
      period(val(i), i[0], i == 2, 1'b0);
    tick(1);
    chk(15'(model.got.size()), 15'h4);
    for (int i = 1; i <= 4; i++)
      chk(model.got[i-1], {i[0] | (i == 2), val(i) ^ {!f, 13'h0}});
  endtask
  task automatic t_stall();
    fmt_n = 1'b1;
    stall = 1'b1;
    do_reset();
    for (int i = 1; i <= 8; i++)
      period(val(i), 1'b0, 1'b0, 1'b0);
    chk(15'(model.got.size()), 15'h0);
    stall = 1'b0;
    tick(6);
    chk(15'(model.got.size()), 15'h2);
    chk(model.got[0], {1'b0, val(1)});
    chk(model.got[1], {1'b0, val(2)});
    den_n = 1'b1;
    tick(1);
    chk({foe, woe}, 15'h7fff);
    den_n = 1'b0;
    tick(1);
    chk({foe, woe}, 15'h0);
  endtask
  initial begin
    t_stream(1'b0);
    t_stream(1'b1);
    t_stall();
    stop_test();
  end
endmodule
bind padc_port padc_asserts chk_i (
  .ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in),
  .encode_clock_pair_p_in(encode_clock_pair_p_in),
  .encode_clock_pair_n_in(encode_clock_pair_n_in),
  .drive_enable_n_in(drive_enable_n_in),
  .sink_ready_in(sink_ready_in),
  .sample_word_out(sample_word_out),
  .sample_word_oe_n_out(sample_word_oe_n_out),
  .range_overflow_flag_out(range_overflow_flag_out),
  .range_overflow_flag_oe_n_out(range_overflow_flag_oe_n_out),
  .data_valid_strobe_out(data_valid_strobe_out)
);
`default_nettype wire
